// >>> rtl/cmrr_pkg.sv
// Constants for the channel minimum and latest result register bank
package cmrr_pkg;
    localparam int RESULT_W = 16;
    localparam int NUM_CH = 8;
    localparam logic [7:0] OFS_CH5_MIN_HIGH = 8'h8B;
    localparam logic [7:0] OFS_CH6_MIN_LOW = 8'h8C;
    localparam logic [7:0] OFS_CH6_MIN_HIGH = 8'h8D;
    localparam logic [7:0] OFS_CH7_MIN_LOW = 8'h8E;
    localparam logic [7:0] OFS_CH7_MIN_HIGH = 8'h8F;
    localparam logic [7:0] OFS_CH0_LATEST_LOW = 8'hA0;
    localparam logic [7:0] OFS_CH0_LATEST_HIGH = 8'hA1;
    localparam logic [7:0] OFS_CH1_LATEST_LOW = 8'hA2;
    localparam logic [7:0] OFS_CH1_LATEST_HIGH = 8'hA3;
    localparam logic [7:0] MIN_BYTE_RESET = 8'hFF;
    localparam logic [7:0] LATEST_BYTE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int HIGH_BYTE_MSB = 15;
    localparam int HIGH_BYTE_LSB = 8;
    localparam int LOW_BYTE_MSB = 7;
    localparam int LOW_BYTE_LSB = 0;
endpackage

// >>> rtl/cmrr_min_tracker.sv
// One channel's lowest-code tracker with per-byte read rearm
`timescale 1ns/10ps
module cmrr_min_tracker #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Result stream
    input wire logic result_valid_i,
    input wire logic [W-1:0] result_i,
    // Read rearm strobes
    input wire logic rearm_low_i,
    input wire logic rearm_high_i,
    // Tracked minimum
    output logic [W-1:0] lowest_o
);
    logic [W-1:0] lowest_reg;
    logic [W-1:0] lowest_next;

    always_comb begin
        lowest_next = lowest_reg;
        if (rearm_low_i) begin
            lowest_next[cmrr_pkg::LOW_BYTE_MSB:cmrr_pkg::LOW_BYTE_LSB] =
                cmrr_pkg::MIN_BYTE_RESET;
        end
        if (rearm_high_i) begin
            lowest_next[cmrr_pkg::HIGH_BYTE_MSB:cmrr_pkg::HIGH_BYTE_LSB] =
                cmrr_pkg::MIN_BYTE_RESET;
        end
        // A result landing with a rearm still counts: compare against the rearmed word
        if (result_valid_i && (result_i < lowest_next)) begin
            lowest_next = result_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lowest_reg <= {cmrr_pkg::MIN_BYTE_RESET, cmrr_pkg::MIN_BYTE_RESET};
        end else begin
            lowest_reg <= lowest_next;
        end
    end

    assign lowest_o = lowest_reg;
endmodule

// >>> rtl/cmrr_bank.sv
// Channel minimum and latest result register bank
`timescale 1ns/10ps
module cmrr_bank #(
    parameter int RESULT_W = cmrr_pkg::RESULT_W,
    parameter int NUM_CH = cmrr_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Conversion results
    input wire logic result_valid_i,
    input wire logic [2:0] result_ch_i,
    input wire logic [RESULT_W-1:0] result_i,
    // Register read port from the serial interface
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    // Read answer
    output logic [7:0] rd_data_o,
    output logic rd_valid_o
);
    // Tracked minimum of each channel, whole word and its two bytes
    logic [RESULT_W-1:0] lowest [NUM_CH];
    logic [7:0] lowest_low_byte [NUM_CH];
    logic [7:0] lowest_high_byte [NUM_CH];

    // Latest result of channels 0 and 1, one register per byte
    logic [7:0] ch0_latest_code_low_byte_reg;
    logic [7:0] ch0_latest_code_low_byte_next;
    logic [7:0] ch0_latest_code_high_byte_reg;
    logic [7:0] ch0_latest_code_high_byte_next;
    logic [7:0] ch1_latest_code_low_byte_reg;
    logic [7:0] ch1_latest_code_low_byte_next;
    logic [7:0] ch1_latest_code_high_byte_reg;
    logic [7:0] ch1_latest_code_high_byte_next;

    // Read answer
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    // Address decode and per-channel strobes
    logic [NUM_CH-1:0] min_low_hit;
    logic [NUM_CH-1:0] min_high_hit;
    logic [NUM_CH-1:0] result_hit;
    logic [NUM_CH-1:0] rearm_low;
    logic [NUM_CH-1:0] rearm_high;

    // Minimum registers sit in byte pairs from 0x80 upward, low byte first
    function automatic logic [7:0] min_low_ofs(input int ch);
        min_low_ofs = cmrr_pkg::OFS_CH6_MIN_LOW - 8'((6 - ch) * 2);
    endfunction

    // High byte of a pair sits one above its low byte
    function automatic logic [7:0] min_high_ofs(input int ch);
        min_high_ofs = min_low_ofs(ch) + 8'h01;
    endfunction

    // True when a result's channel field names this channel
    function automatic logic ch_match(input logic [2:0] sel, input int ch);
        ch_match = (sel == 3'(ch));
    endfunction

    // Top eight bits of a result word and the eight just below them
    function automatic logic [7:0] high_of(input logic [RESULT_W-1:0] w);
        high_of = w[RESULT_W-1 -: 8];
    endfunction

    function automatic logic [7:0] low_of(input logic [RESULT_W-1:0] w);
        low_of = w[RESULT_W-9 -: 8];
    endfunction

    // Address decode, shared by the rearm strobes and the read mux
    always_comb begin
        min_low_hit = '0;
        min_high_hit = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            min_low_hit[c] = (rd_addr_i == min_low_ofs(c));
            min_high_hit[c] = (rd_addr_i == min_high_ofs(c));
        end
    end

    // Per-channel result and rearm strobes
    always_comb begin
        result_hit = '0;
        rearm_low = '0;
        rearm_high = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            result_hit[c] = result_valid_i && ch_match(result_ch_i, c);
            rearm_low[c] = rd_en_i && min_low_hit[c];
            rearm_high[c] = rd_en_i && min_high_hit[c];
        end
    end

    // One tracker per channel; a read rearms only the byte it returned
    for (genvar g = 0; g < NUM_CH; g++) begin : g_min
        cmrr_min_tracker #(
            .W(RESULT_W)
        ) u_trk (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .result_valid_i(result_hit[g]),
            .result_i(result_i),
            .rearm_low_i(rearm_low[g]),
            .rearm_high_i(rearm_high[g]),
            .lowest_o(lowest[g])
        );
    end

    // Byte views of each tracked minimum for the read mux
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            lowest_low_byte[c] = low_of(lowest[c]);
            lowest_high_byte[c] = high_of(lowest[c]);
        end
    end

    // Channel 0 latest result; every new result replaces it, no compare
    always_comb begin
        ch0_latest_code_high_byte_next = ch0_latest_code_high_byte_reg;
        ch0_latest_code_low_byte_next = ch0_latest_code_low_byte_reg;
        if (result_hit[0]) begin
            ch0_latest_code_high_byte_next = high_of(result_i);
            ch0_latest_code_low_byte_next = low_of(result_i);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch0_latest_code_high_byte_reg <= cmrr_pkg::LATEST_BYTE_RESET;
            ch0_latest_code_low_byte_reg <= cmrr_pkg::LATEST_BYTE_RESET;
        end else begin
            ch0_latest_code_high_byte_reg <= ch0_latest_code_high_byte_next;
            ch0_latest_code_low_byte_reg <= ch0_latest_code_low_byte_next;
        end
    end

    // Channel 1 latest result; every new result replaces it, no compare
    always_comb begin
        ch1_latest_code_high_byte_next = ch1_latest_code_high_byte_reg;
        ch1_latest_code_low_byte_next = ch1_latest_code_low_byte_reg;
        if (result_hit[1]) begin
            ch1_latest_code_high_byte_next = high_of(result_i);
            ch1_latest_code_low_byte_next = low_of(result_i);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch1_latest_code_high_byte_reg <= cmrr_pkg::LATEST_BYTE_RESET;
            ch1_latest_code_low_byte_reg <= cmrr_pkg::LATEST_BYTE_RESET;
        end else begin
            ch1_latest_code_high_byte_reg <= ch1_latest_code_high_byte_next;
            ch1_latest_code_low_byte_reg <= ch1_latest_code_low_byte_next;
        end
    end

    // Read mux returns the value held before any rearm in this cycle
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_en_i) begin
            rd_data_next = cmrr_pkg::UNMAPPED_READ;
            for (int c = 0; c < NUM_CH; c++) begin
                if (min_low_hit[c]) begin
                    rd_data_next = lowest_low_byte[c];
                end
                if (min_high_hit[c]) begin
                    rd_data_next = lowest_high_byte[c];
                end
            end
            case (rd_addr_i)
                cmrr_pkg::OFS_CH0_LATEST_LOW: begin
                    rd_data_next = ch0_latest_code_low_byte_reg;
                end
                cmrr_pkg::OFS_CH0_LATEST_HIGH: begin
                    rd_data_next = ch0_latest_code_high_byte_reg;
                end
                cmrr_pkg::OFS_CH1_LATEST_LOW: begin
                    rd_data_next = ch1_latest_code_low_byte_reg;
                end
                cmrr_pkg::OFS_CH1_LATEST_HIGH: begin
                    rd_data_next = ch1_latest_code_high_byte_reg;
                end
                default: ;
            endcase
        end
    end

    // Data stands from one read until the next
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= cmrr_pkg::UNMAPPED_READ;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Valid pulses for one cycle after each read, mapped or not
    always_comb begin
        rd_valid_next = rd_en_i;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
endmodule

// >>> tb/cmrr_host.sv
// Host-side model issuing register reads
`timescale 1ns/10ps
module cmrr_host (
    // Clock and answer
    input wire logic sys_clk_i,
    input wire logic [7:0] rd_data_i,
    // Read request
    output logic rd_en_o,
    output logic [7:0] rd_addr_o
);
    initial begin
        rd_en_o = 1'b0;
        rd_addr_o = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        rd_en_o = 1'b1;
        rd_addr_o = a;
        @(negedge sys_clk_i);
        d = rd_data_i;
        rd_en_o = 1'b0;
        rd_addr_o = ~a;
    endtask
endmodule

// >>> tb/cmrr_bank_sva.sv
// Port assertions for the result register bank
`timescale 1ns/10ps
module cmrr_bank_sva #(parameter int RESULT_W = 16) (
    // Inputs
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic result_valid_i,
    input wire logic [2:0] result_ch_i,
    input wire logic [RESULT_W-1:0] result_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    // Outputs
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    read_valid_a: assert property (rd_valid_o == $past(rd_en_i)) else $error("bad valid");
    data_hold_a: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("data moved");
    unmapped_a: assert property (rd_en_i && rd_addr_i >= 8'hA4 |=> rd_data_o == 8'h00)
        else $error("unmapped data");
    rearm_a: assert property ((rd_en_i && rd_addr_i == 8'h8C && !result_valid_i) ##1
        !result_valid_i ##1 (rd_en_i && rd_addr_i == 8'h8C) |=> rd_data_o == 8'hFF) else $error("no rearm");
    latest_high_a: assert property ((result_valid_i && result_ch_i == 3'h0) ##1
        !result_valid_i ##1 (rd_en_i && rd_addr_i == 8'hA1)
        |=> rd_data_o == $past(result_i[RESULT_W-1 -: 8], 3))
        else $error("bad high");
    latest_low_a: assert property ((result_valid_i && result_ch_i == 3'h1) ##1
        !result_valid_i ##1 (rd_en_i && rd_addr_i == 8'hA2)
        |=> rd_data_o == $past(result_i[RESULT_W-9 -: 8], 3))
        else $error("bad low");
    latest_keep_a: assert property ((rd_en_i && rd_addr_i == 8'hA1 && !result_valid_i) ##1
        !result_valid_i ##1 (rd_en_i && rd_addr_i == 8'hA1) |=> rd_data_o == $past(rd_data_o, 2))
        else $error("latest changed");
    ch7_min_a: assert property ((result_valid_i && result_ch_i == 3'h7 && !rd_en_i) ##1
        !rd_en_i ##1 (rd_en_i && rd_addr_i == 8'h8F) |=> rd_data_o <= $past(result_i[15:8], 3))
        else $error("min too high");
    cover property (rd_en_i && rd_addr_i == 8'h8C);
    cover property (result_valid_i && result_ch_i == 3'h6);
    cover property (rd_en_i && rd_addr_i == 8'hA2);
endmodule
bind cmrr_bank cmrr_bank_sva #(.RESULT_W(RESULT_W)) cmrr_bank_sva_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .result_valid_i(result_valid_i), .result_ch_i(result_ch_i),
    .result_i(result_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o));

// >>> tb/tb_top.sv
// Self-checking bench for the result register bank
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic result_valid_i = 1'b0;
    logic [2:0] result_ch_i = 3'h0;
    logic [15:0] result_i = 16'h0000;
    logic rd_en_i, rd_valid_o;
    logic [7:0] rd_addr_i, rd_data_o, d;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    cmrr_bank cmrr_bank_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .result_valid_i(result_valid_i),
        .result_ch_i(result_ch_i), .result_i(result_i), .rd_en_i(rd_en_i),
        .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
    cmrr_host cmrr_host_i (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data_o), .rd_en_o(rd_en_i),
        .rd_addr_o(rd_addr_i));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic res(input logic [2:0] ch, input logic [15:0] v);
        @(negedge sys_clk_i);
        result_valid_i = 1'b1;
        result_ch_i = ch;
        result_i = v;
        @(negedge sys_clk_i);
        result_valid_i = 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        cmrr_host_i.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            rchk(8'h8C + 8'(i), 8'hFF);
            rchk(8'hA0 + 8'(i), 8'h00);
        end
        $display("reset test done");
    endtask
    task automatic t_min;
        res(3'h6, 16'h1230);
        res(3'h6, 16'h11F0);
        res(3'h6, 16'h1240);
        rchk(8'h8C, 8'hF0);
        rchk(8'h8C, 8'hFF);
        rchk(8'h8D, 8'h11);
        rchk(8'h8D, 8'hFF);
        res(3'h7, 16'h0102);
        rchk(8'h8F, 8'h01);
        rchk(8'h8E, 8'h02);
        res(3'h5, 16'h4321);
        rchk(8'h8B, 8'h43);
        $display("minimum test done");
    endtask
    task automatic t_latest;
        res(3'h0, 16'hABCD);
        rchk(8'hA1, 8'hAB);
        rchk(8'hA1, 8'hAB);
        rchk(8'hA0, 8'hCD);
        res(3'h1, 16'h1357);
        rchk(8'hA2, 8'h57);
        rchk(8'hA3, 8'h13);
        rchk(8'hB0, 8'h00);
        $display("latest test done");
    endtask
    task automatic t_rerun;
        res(3'h6, 16'h0102);
        res(3'h0, 16'hBEEF);
        @(negedge sys_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        rchk(8'h8D, 8'hFF);
        rchk(8'h8C, 8'hFF);
        rchk(8'hA1, 8'h00);
        rchk(8'hA0, 8'h00);
        $display("reset rerun test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_min();
        t_latest();
        t_rerun();
        end_of_test();
    end
endmodule
